// ==== common/flash_prog_defs.svh ====
// Constants of the flash page programming parameter checker
`ifndef FLASH_PROG_DEFS_SVH
`define FLASH_PROG_DEFS_SVH

// Page geometry
`define FPC_PAGE_BYTES 128
`define FPC_PAGE_CNT_W 8
`define FPC_ALIGN_BITS 7

// Supported frequency codes: 10.00 MHz and 33.00 MHz times 100
`define FPC_FREQ_MIN 16'h03E8
`define FPC_FREQ_MAX 16'h0CE4

// Result bit positions
`define FPC_FAIL_BIT 0
`define FPC_FREQ_ERR_BIT 1
`define FPC_DEST_ERR_BIT 1
`define FPC_SRC_ERR_BIT 2

// Reset value and FIFO depth
`define FPC_RESULT_RST 8'h00
`define FPC_FIFO_DEPTH 16

`endif

// ==== common/flash_prog_pkg.sv ====
// Types shared by the flash page programming parameter checker
package flash_prog_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        st_idle,
        st_xfer
    } state_t;

    // One byte written into the user flash array
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0] data;
    } flash_wr_t;

endpackage

// ==== hdl/page_fifo.sv ====
// Byte FIFO between source reads and flash array writes
`timescale 1ns/1ps
module page_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic out_valid_q;
    logic [WIDTH-1:0] out_data_q;

    // ------------------------------------------------------------
    // Handshake decode
    // ------------------------------------------------------------
    // Output stage is a register so read data never comes straight from the array
    wire push = in_valid && in_ready;
    wire load = (cnt_q != '0) && (!out_valid_q || out_ready);
    assign in_ready = cnt_q != (AW+1)'(DEPTH);
    assign out_valid = out_valid_q;
    assign out_data = out_data_q;
    assign level = cnt_q;

    // Storage array, no reset needed
    always_ff @(posedge sys_clk) begin
        if (ce && push) begin
            mem[wp_q] <= in_data;
        end
    end

    // Pointers, fill count and output stage
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (ce) begin
            if (push) wp_q <= wp_q + 1'b1;
            if (load) begin
                rp_q <= rp_q + 1'b1;
                out_data_q <= mem[rp_q];
            end
            if (load) out_valid_q <= 1'b1;
            else if (out_ready) out_valid_q <= 1'b0;
            if (push && !load) cnt_q <= cnt_q + 1'b1;
            else if (!push && load) cnt_q <= cnt_q - 1'b1;
        end
    end
endmodule // page_fifo

// ==== hdl/flash_program_param_checker.sv ====
// Parameter checker and page mover for flash init and programming calls
`timescale 1ns/1ps
`include "flash_prog_defs.svh"

// Overview of operation
// - Initialization sets the frequency error bit when the code is out of range, else clears it.
// - The supported range is 10 to 33 MHz inclusive.
// - Initialization returns bit 0 as the fail flag and bits 7 to 2 as zero.
// - Programming writes 128 consecutive bytes from the destination start address.
// - A destination not on a 128-byte boundary sets the address error bit 1.
// - A destination outside the flash space is reported as an error.
// - Programming reads 128 consecutive source bytes and writes them in order.
// - A source address inside flash sets the dedicated source error bit.
module flash_program_param_checker
    import flash_prog_pkg::*;
#(
    parameter logic [31:0] FLASH_BASE = 32'h0000_0000,
    parameter logic [31:0] FLASH_SIZE = 32'h0004_0000,
    parameter int FIFO_DEPTH = `FPC_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic init_start,
    input wire logic prog_start,
    input wire logic [31:0] first_general_register,
    input wire logic [31:0] second_general_register,
    input wire logic src_ack,
    input wire logic [7:0] src_data,
    input wire logic flash_wr_ready,
    output logic busy_q,
    output logic done_q,
    output logic [7:0] pass_fail_result_q,
    output logic src_req_q,
    output logic [31:0] src_addr_q,
    output logic flash_wr_valid_q,
    output flash_prog_pkg::flash_wr_t flash_wr_q
);
    import flash_prog_pkg::*;

    localparam int CW = `FPC_PAGE_CNT_W;
    localparam logic [CW-1:0] PAGE = CW'(`FPC_PAGE_BYTES);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;

    state_t state_q;
    logic [31:0] dest_q;
    logic [31:0] src_q;
    logic [CW-1:0] rd_cnt_q;
    logic [CW-1:0] wr_cnt_q;
    logic [CW-1:0] iss_cnt_q;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [LW-1:0] fifo_level;

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // Only the low half is looked at; the caller keeps the top zero
    wire [15:0] freq_code = first_general_register[15:0];
    wire freq_err = (freq_code < `FPC_FREQ_MIN) ||
                    (freq_code > `FPC_FREQ_MAX);
    wire [31:0] dest_off = second_general_register - FLASH_BASE;
    wire [31:0] src_off = first_general_register - FLASH_BASE;
    wire dest_align_err =
        second_general_register[`FPC_ALIGN_BITS-1:0] != '0;
    wire dest_range_err = dest_off >= FLASH_SIZE;
    wire src_range_err = src_off < FLASH_SIZE;
    wire prog_err = dest_align_err || dest_range_err || src_range_err;
    wire idle = state_q == st_idle;
    wire init_go = ce && idle && init_start;
    wire prog_go = ce && idle && !init_start && prog_start;

    // Result byte images; unused bits stay zero
    wire [7:0] init_res = {6'h00, freq_err, freq_err};
    wire [7:0] prog_res = {5'h00, src_range_err, dest_align_err,
                           prog_err};

    // ------------------------------------------------------------
    // Page data path
    // ------------------------------------------------------------
    // Requests stop one short of full so a registered request never
    // overruns the FIFO
    wire src_take = src_req_q && src_ack && fifo_in_ready;
    wire [CW-1:0] rd_cnt_d = rd_cnt_q + CW'(src_take);
    wire src_req_d = (state_q == st_xfer) && (rd_cnt_d < PAGE) &&
                     (fifo_level < LW'(FIFO_DEPTH - 1));
    wire fifo_pop_ok = !flash_wr_valid_q || flash_wr_ready;
    wire fifo_pop = fifo_out_valid && fifo_pop_ok;
    wire wr_accept = flash_wr_valid_q && flash_wr_ready;
    wire page_end = wr_accept && (wr_cnt_q == PAGE - 1'b1);

    page_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .in_valid(src_take),
        .in_ready(fifo_in_ready),
        .in_data(src_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop_ok),
        .out_data(fifo_out_data),
        .level(fifo_level)
    );

    // Sequencer and parameter latch
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= st_idle;
            dest_q <= '0;
            src_q <= '0;
            pass_fail_result_q <= `FPC_RESULT_RST;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else if (ce) begin
            done_q <= 1'b0;
            if (init_go) begin
                pass_fail_result_q <= init_res;
                done_q <= 1'b1;
            end else if (prog_go) begin
                dest_q <= second_general_register;
                src_q <= first_general_register;
                pass_fail_result_q <= prog_res;
                if (prog_err) begin
                    done_q <= 1'b1;
                end else begin
                    state_q <= st_xfer;
                    busy_q <= 1'b1;
                end
            end else if (state_q == st_xfer && page_end) begin
                state_q <= st_idle;
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end

    // Source side: consecutive byte reads from the source start
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_cnt_q <= '0;
            src_req_q <= 1'b0;
            src_addr_q <= '0;
        end else if (ce) begin
            rd_cnt_q <= prog_go ? '0 : rd_cnt_d;
            src_req_q <= src_req_d;
            src_addr_q <= src_q + {24'h000000, rd_cnt_d};
        end
    end

    // Flash side: bytes go out in order to consecutive addresses
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            iss_cnt_q <= '0;
            wr_cnt_q <= '0;
            flash_wr_valid_q <= 1'b0;
            flash_wr_q <= '0;
        end else if (ce) begin
            if (prog_go) begin
                iss_cnt_q <= '0;
                wr_cnt_q <= '0;
            end else begin
                if (fifo_pop) iss_cnt_q <= iss_cnt_q + 1'b1;
                if (wr_accept) wr_cnt_q <= wr_cnt_q + 1'b1;
            end
            if (fifo_pop) begin
                flash_wr_valid_q <= 1'b1;
                flash_wr_q.addr <= dest_q + {24'h000000, iss_cnt_q};
                flash_wr_q.data <= fifo_out_data;
            end else if (flash_wr_ready) begin
                flash_wr_valid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Each result flag is checked against the parameters seen at the call
    a_freq_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        init_go |=> pass_fail_result_q[`FPC_FREQ_ERR_BIT] ==
            ($past(freq_code) < 16'h03E8 || $past(freq_code) > 16'h0CE4))
        else $error("frequency flag wrong");
    a_freq_edges: assert property (@(posedge sys_clk) disable iff (!rstn)
        init_go && (freq_code == 16'h03E8 || freq_code == 16'h0CE4)
            |=> !pass_fail_result_q[`FPC_FREQ_ERR_BIT] && done_q)
        else $error("range edge rejected");
    a_init_result: assert property (@(posedge sys_clk) disable iff (!rstn)
        init_go |=> pass_fail_result_q[7:2] == 6'h00 &&
            pass_fail_result_q[0] == pass_fail_result_q[1])
        else $error("init result bits wrong");
    a_dest_align: assert property (@(posedge sys_clk) disable iff (!rstn)
        prog_go && second_general_register[6:0] != 7'h00
            |=> pass_fail_result_q[`FPC_DEST_ERR_BIT] && pass_fail_result_q[0])
        else $error("unaligned destination passed");
    a_dest_range: assert property (@(posedge sys_clk) disable iff (!rstn)
        prog_go && dest_range_err |=> pass_fail_result_q[`FPC_FAIL_BIT])
        else $error("destination range not flagged");
    a_src_range: assert property (@(posedge sys_clk) disable iff (!rstn)
        prog_go |=> pass_fail_result_q[`FPC_SRC_ERR_BIT] == $past(src_range_err))
        else $error("source flag wrong");
    a_no_write_err: assert property (@(posedge sys_clk) disable iff (!rstn)
        prog_go && prog_err |=>
            (idle && !busy_q && !src_req_q && !flash_wr_valid_q) ##1
            (!src_req_q && !flash_wr_valid_q))
        else $error("write started after failed check");
    a_wr_order: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && wr_accept |-> flash_wr_q.addr == dest_q + {24'h000000, wr_cnt_q})
        else $error("write address out of sequence");
    a_page_count: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && busy_q && page_end |=> !busy_q && done_q && rd_cnt_q == 8'h80)
        else $error("page did not end at 128 bytes");
    // Source reads step by one byte per accepted request
    a_src_step: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && src_take |=> src_addr_q == $past(src_addr_q) + 32'h1)
        else $error("source address skipped");
endmodule // flash_program_param_checker

// ==== dv/flash_program_param_checker_test.sv ====
// Self-checking bench for the flash page programming parameter checker
`timescale 1ns/1ps
`include "flash_prog_defs.svh"
module flash_program_param_checker_test;
    import flash_prog_pkg::*;
    // --------------------------------------------------------------
    // Signals and bookkeeping
    // --------------------------------------------------------------
    localparam logic [31:0] FSIZE = 32'h0004_0000;
    logic sys_clk = 1'b0, rstn = 1'b0, ce = 1'b1;
    logic init_start = 1'b0, prog_start = 1'b0;
    logic src_ack = 1'b0, flash_wr_ready = 1'b0;
    logic [31:0] r0 = 32'h0, r1 = 32'h0, v, seed = 32'h0000_003A;
    logic [7:0] src_data = 8'h00, pass_fail_result_q;
    logic busy_q, done_q, src_req_q, flash_wr_valid_q;
    logic [31:0] src_addr_q, src_base = 32'h0;
    flash_wr_t flash_wr_q;
    logic [7:0] res_q[$];
    flash_wr_t wr_q[$];
    logic [7:0] page[128];
    int failures = 0, checks = 0, scnt = 0, plen = 128;
    logic [7:0] note;
    flash_wr_t wr_note;

    flash_program_param_checker #(.FLASH_SIZE(FSIZE)) dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .init_start(init_start), .prog_start(prog_start),
        .first_general_register(r0), .second_general_register(r1),
        .src_ack(src_ack), .src_data(src_data),
        .flash_wr_ready(flash_wr_ready), .busy_q(busy_q), .done_q(done_q),
        .pass_fail_result_q(pass_fail_result_q), .src_req_q(src_req_q),
        .src_addr_q(src_addr_q), .flash_wr_valid_q(flash_wr_valid_q),
        .flash_wr_q(flash_wr_q)
    );

    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    // Xorshift keeps the run repeatable from the fixed seed
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One call; waits for idle first so the start is never swallowed
    task automatic run(input logic ini, input logic [31:0] a, b);
        int n;
        n = 0;
        @(negedge sys_clk);
        while (busy_q) @(negedge sys_clk);
        init_start = ini;
        prog_start = !ini;
        r0 = a;
        r1 = b;
        @(negedge sys_clk);
        init_start = 1'b0;
        prog_start = 1'b0;
        // Only a clean programming call may leave the block busy
        check(busy_q, !ini && res_q[$] == 8'h00);
        while (!done_q && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 3000) check(40'h0, 40'h1);
    endtask

    task automatic init_call(input logic [15:0] code);
        res_q.push_back((code < `FPC_FREQ_MIN || code > `FPC_FREQ_MAX) ?
                        8'h03 : 8'h00);
        run(1'b1, {16'h0000, code}, 32'h0);
    endtask

    // Expected flags: bit 1 misaligned, bit 2 source in flash, bit 0 any
    task automatic prog_call(input logic [31:0] s, d);
        logic [7:0] e;
        e = 8'h00;
        e[1] = (d[6:0] != 7'h00);
        e[2] = (s < FSIZE);
        e[0] = (d >= FSIZE) || (e != 8'h00);
        res_q.push_back(e);
        if (e == 8'h00) begin
            src_base = s;
            scnt = 0;
            for (int i = 0; i < 128; i++) begin
                v = rnd();
                page[i] = (i < plen) ? v[7:0] : 8'hFF;
                wr_q.push_back({d + 32'(i), page[i]});
            end
        end
        run(1'b0, s, d);
    endtask

    // --------------------------------------------------------------
    // Clock, far-side responders, monitor, watchdog
    // --------------------------------------------------------------
    initial forever #2.5 sys_clk = ~sys_clk;

    // Random stalls on both sides; ce only drops while a page moves
    always @(negedge sys_clk) begin
        v = rnd();
        ce = !busy_q || (v[1:0] != 2'h0);
        src_ack = v[2];
        src_data = page[7'(src_addr_q - src_base)];
        flash_wr_ready = v[3] | v[4];
    end

    // Oldest result note off its queue whenever the design shows a result, oldest write note on each accepted write
    always @(posedge sys_clk) begin
        if (rstn && ce) begin
            if (done_q) begin
                if (res_q.size() == 0) begin
                    check(40'h0, 40'h1);
                end else begin
                    note = res_q.pop_front();
                    check(pass_fail_result_q, note);
                end
            end
            if (src_req_q && src_ack) begin
                check(src_addr_q, src_base + 32'(scnt));
                scnt++;
            end
            if (flash_wr_valid_q && flash_wr_ready) begin
                if (wr_q.size() == 0) begin
                    check(40'h1, 40'h0);
                end else begin
                    wr_note = wr_q.pop_front();
                    check(flash_wr_q, wr_note);
                end
            end
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        stop_test();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        check({busy_q, done_q, src_req_q, flash_wr_valid_q}, 40'h0);
        check({src_addr_q, pass_fail_result_q}, 40'h0);
        check(flash_wr_q, 40'h0);
        @(negedge sys_clk);
        rstn = 1'b1;
        // Range edges, then random codes either side of them
        init_call(16'h03E7);
        init_call(16'h03E8);
        init_call(16'h0CE4);
        init_call(16'h0CE5);
        init_call(16'h0000);
        for (int i = 0; i < 6; i++) begin
            v = rnd();
            init_call({4'h0, v[11:0]});
        end
        // Refused programming calls must leave the array alone
        prog_call(32'h2000_0000, FSIZE - 32'h7F);
        prog_call(32'h2000_0000, FSIZE);
        prog_call(FSIZE - 32'h1, 32'h0000_0080);
        prog_call(32'h0000_0000, FSIZE + 32'h40);
        prog_call(32'h2000_0000, 32'h0000_0001);
        // Good pages at both boundary forms, the second with its source just past flash
        prog_call(32'h2000_0000, 32'h0000_0000);
        // Short page: only the first 40 bytes carry data, the rest filler
        plen = 40;
        prog_call(FSIZE, FSIZE - 32'h80);
        plen = 128;
        init_call(16'h0BB8);
        // Four times 8.25 MHz: the multiplied 33.00 MHz is what is encoded
        init_call(16'(4 * 825));
        repeat (5) @(negedge sys_clk);
        check(40'(wr_q.size() + res_q.size()), 40'h0);
        stop_test();
    end
endmodule // flash_program_param_checker_test
